// ==== bench/bcc_host.sv ====
// host model: drives the register strobe port of the clock core
// assumes one rising-edge clock; callers enter tasks just after a rising edge
`timescale 1ns/1ps
module bcc_host (
	// clock
	input logic core_clk,
	// register port
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// idle address and data are inverted so a stale value cannot pass for a live one
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		@(posedge core_clk);
	endtask : wr
	// write, then let the four-cycle landing delay pass
	task automatic wrs(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		repeat (2) @(posedge core_clk);
	endtask : wrs
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge core_clk);
		d = reg_rdata;
		@(posedge core_clk);
	endtask : rd
	task automatic unlock();
		wr(bcc_pkg::OFS_KEY0, bcc_pkg::KEY_FIRST);
		wr(bcc_pkg::OFS_KEY1, bcc_pkg::KEY_SECOND);
	endtask : unlock
endmodule : bcc_host

// ==== bench/tb_bcd_calendar_clock_core.sv ====
// self-checking bench of the bcd calendar clock core
// assumes the host model of bcc_host.sv and a shortened second
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_bcd_calendar_clock_core;
	typedef struct packed {
		logic fmt;
		bcc_pkg::bcc_time_t st;
		bcc_pkg::bcc_time_t ex;
	} bcc_row_t;
	// 100 reference edges make one second, so a tick costs hundreds of cycles, not millions
	localparam int REF_SIM = 100;
	localparam logic [31:0] LEAK = 32'h00000008; // disable bit left clear throughout
	logic core_clk;
	logic sys_rst;
	logic osc_in_pin;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic osc_out_pin;
	logic leakage_isolation_enable;
	int miscompares = 0;
	int checked = 0;
	logic [31:0] v;
	logic [7:0] offs [7];
	bcc_row_t rows [11];

	bcc_core #(.REF_PER(REF_SIM)) uut (
		.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_in_pin(osc_in_pin),
		.osc_out_pin(osc_out_pin), .leakage_isolation_enable(leakage_isolation_enable));
	bcc_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		osc_in_pin = 1'b0;
		forever begin
			repeat (2) @(posedge core_clk);
			osc_in_pin <= ~osc_in_pin;
		end
	end
	// fields given as bytes: weekday year month day meridiem hour minute second
	function automatic bcc_pkg::bcc_time_t tm(input logic [63:0] x);
		return {x[58:56], x[55:48], x[44:40], x[37:32], x[24], x[21:16], x[14:8], x[6:0]};
	endfunction : tm
	function automatic logic [31:0] fld(input bcc_pkg::bcc_time_t t, input int i);
		case (i)
			0: return {25'h0, t.sc};
			1: return {25'h0, t.mn};
			2: return {24'h0, t.pm, 1'b0, t.hr};
			3: return {26'h0, t.day};
			4: return {27'h0, t.mon};
			5: return {24'h0, t.yr};
			default: return {29'h0, t.wd};
		endcase
	endfunction : fld
	task automatic done(input string n);
		$display("test %s done", n);
	endtask : done
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	// polling is bounded; a busy bit that never moves ends as a mismatch
	task automatic busy(input logic lvl);
		int n;
		n = 0;
		host.rd(bcc_pkg::OFS_STAT, v);
		while (v[bcc_pkg::SB_BUSY] !== lvl && n < 3000) begin
			host.rd(bcc_pkg::OFS_STAT, v);
			n++;
		end
		`CHK(v[bcc_pkg::SB_BUSY], lvl)
	endtask : busy
	// time is only written while counting is stopped
	task automatic tick_row(input bcc_row_t r);
		for (int i = 0; i < 7; i++)
			host.wr(offs[i], fld(r.st, i));
		host.wrs(bcc_pkg::OFS_CTRL, LEAK | {29'h0, r.fmt, 2'b01});
		busy(1'b1);
		busy(1'b0);
		host.wr(bcc_pkg::OFS_CTRL, LEAK | {29'h0, r.fmt, 2'b00});
		for (int i = 0; i < 7; i++) begin
			host.rd(offs[i], v);
			`CHK(v, fld(r.ex, i))
		end
	endtask : tick_row

	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		close_out();
	end

	initial begin
		sys_rst = 1'b1;
		offs = '{bcc_pkg::OFS_SEC, bcc_pkg::OFS_MIN, bcc_pkg::OFS_HOUR, bcc_pkg::OFS_DAY,
			bcc_pkg::OFS_MON, bcc_pkg::OFS_YEAR, bcc_pkg::OFS_WDAY};
		rows[0] = '{1'b0, tm(64'h01_25_03_10_00_09_14_59), tm(64'h01_25_03_10_00_09_15_00)};
		rows[1] = '{1'b0, tm(64'h01_25_03_10_00_23_59_59), tm(64'h02_25_03_11_00_00_00_00)};
		rows[2] = '{1'b0, tm(64'h06_23_02_28_00_23_59_59), tm(64'h00_23_03_01_00_00_00_00)};
		rows[3] = '{1'b0, tm(64'h03_24_02_28_00_23_59_59), tm(64'h04_24_02_29_00_00_00_00)};
		rows[4] = '{1'b0, tm(64'h04_24_02_29_00_23_59_59), tm(64'h05_24_03_01_00_00_00_00)};
		rows[5] = '{1'b0, tm(64'h02_25_04_30_00_23_59_59), tm(64'h03_25_05_01_00_00_00_00)};
		rows[6] = '{1'b0, tm(64'h05_99_12_31_00_23_59_59), tm(64'h06_00_01_01_00_00_00_00)};
		rows[7] = '{1'b1, tm(64'h01_25_06_15_00_11_59_59), tm(64'h01_25_06_15_01_12_00_00)};
		rows[8] = '{1'b1, tm(64'h01_25_06_15_01_12_59_59), tm(64'h01_25_06_15_01_01_00_00)};
		rows[9] = '{1'b1, tm(64'h01_25_06_15_01_11_59_59), tm(64'h02_25_06_16_00_12_00_00)};
		rows[10] = '{1'b0, tm(64'h01_25_06_15_01_11_59_59), tm(64'h01_25_06_15_01_12_00_00)};
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		host.rd(bcc_pkg::OFS_CTRL, v);
		`CHK(v, 32'h00000000)
		host.rd(bcc_pkg::OFS_STAT, v);
		`CHK(v, 32'h00000000)
		host.rd(8'hFC, v);
		`CHK(v, 32'h00000000)
		done("reset");
		host.wrs(bcc_pkg::OFS_CTRL, LEAK);
		host.rd(bcc_pkg::OFS_CTRL, v);
		`CHK(v, 32'h00000000)
		`CHK(leakage_isolation_enable, 1'b0)
		host.unlock();
		host.rd(bcc_pkg::OFS_STAT, v);
		`CHK(v, 32'h00000004)
		host.wrs(bcc_pkg::OFS_CTRL, LEAK);
		`CHK(leakage_isolation_enable, 1'b1)
		done("protect");
		host.wrs(bcc_pkg::OFS_SEC, 32'h00000010);
		host.wr(bcc_pkg::OFS_SEC, 32'h00000015);
		@(posedge core_clk);
		host.rd(bcc_pkg::OFS_SEC, v);
		`CHK(v, 32'h00000010)
		host.wr(bcc_pkg::OFS_SEC, 32'h00000027);
		repeat (2) @(posedge core_clk);
		host.rd(bcc_pkg::OFS_SEC, v);
		`CHK(v, 32'h00000027)
		done("latency");
		host.wrs(bcc_pkg::ALM_BASE + bcc_pkg::OFS_HOUR, 32'h00000092);
		host.rd(bcc_pkg::ALM_BASE + bcc_pkg::OFS_HOUR, v);
		`CHK(v, 32'h00000092)
		host.wrs(bcc_pkg::ALM_BASE + bcc_pkg::OFS_YEAR, 32'h00000099);
		host.rd(bcc_pkg::ALM_BASE + bcc_pkg::OFS_YEAR, v);
		`CHK(v, 32'h00000099)
		done("alarm");
		host.wrs(bcc_pkg::OFS_MIN, 32'h00000030);
		host.rd(bcc_pkg::OFS_SEC, v);
		host.wrs(bcc_pkg::OFS_MIN, 32'h00000031);
		host.rd(bcc_pkg::OFS_MIN, v);
		`CHK(v, 32'h00000030)
		host.rd(bcc_pkg::OFS_SEC, v);
		host.rd(bcc_pkg::OFS_MIN, v);
		`CHK(v, 32'h00000031)
		done("shadow");
		host.wrs(bcc_pkg::OFS_SEC, 32'h00000045);
		host.wrs(bcc_pkg::OFS_CTRL, LEAK | 32'h00000002);
		host.rd(bcc_pkg::OFS_SEC, v);
		`CHK(v, 32'h00000000)
		host.rd(bcc_pkg::OFS_SEC, v);
		host.rd(bcc_pkg::OFS_MIN, v);
		`CHK(v, 32'h00000032)
		host.rd(bcc_pkg::OFS_CTRL, v);
		`CHK(v, LEAK)
		host.wrs(bcc_pkg::OFS_SEC, 32'h00000045);
		host.rd(bcc_pkg::OFS_SEC, v);
		`CHK(v, 32'h00000045)
		done("round");
		foreach (rows[i])
			tick_row(rows[i]);
		done("calendar");
		repeat (1000) @(posedge core_clk);
		host.rd(bcc_pkg::OFS_SEC, v);
		`CHK(v, 32'h00000000)
		done("stopped");
		host.wr(bcc_pkg::OFS_KEY0, 32'h00000000);
		host.rd(bcc_pkg::OFS_STAT, v);
		`CHK(v, 32'h00000000)
		host.wrs(bcc_pkg::OFS_CTRL, 32'h00000000);
		host.rd(bcc_pkg::OFS_CTRL, v);
		`CHK(v, LEAK)
		done("relock");
		close_out();
	end
endmodule : tb_bcd_calendar_clock_core

// ==== hdl/bcc_core.sv ====
// bcd time and calendar core with write protection and busy window
// assumes osc_in_pin is synchronous to core_clk and toggles at the reference rate
`timescale 1ns/1ps

// Contract
// [R1] advance time once per second from the reference clock while running
// [R2] all time and calendar fields are held in bcd
// [R3] seconds and minutes count 00 to 59, then wrap and carry
// [R4] hours count 01-12 in twelve-hour, 00-23 in twenty-four-hour form
// [R5] day of month counts from 01, rolls into month at month end
// [R6] month counts 01 to 12, wraps to 01 and advances the year
// [R7] year holds two bcd digits 00 to 99 and wraps
// [R8] weekday is three bits cycling 0 to 6, advancing at each day rollover
// [R9] february has 29 days in leap years, 28 otherwise; other months proper
// [R10] alarm registers share the time field encoding and widths
// [R11] hour format 0 keeps twenty-four-hour time, meridiem bit ignored
// [R12] hour format 1 keeps twelve-hour time, meridiem 0 am, 1 pm
// [R13] reading seconds copies all time fields into a shadow snapshot
// [R14] round bit set: next seconds read rounds to nearest minute, once
// [R15] run bit cleared stops all automatic updates
// [R16] busy reads low only if no update comes for 15 us
// [R17] host stops counting or sees busy low before writing time
// [R18] written time value lands four cycles later; earlier reads see old
// [R19] host never clears the disable bit once it has set it
// [R20] split-power bit drives the leakage isolation enable
// [R21] no reliance on power-on reset; time persists across system reset
// [R22] every register except the keys ignores writes while protected
// [R23] first key then second key unlocks; any key write relocks
// [R24] busy rises before each update and falls once it completes
// [R25] twelve-hour mode goes 12 to 01 and toggles meridiem at 11 to 12
// [R26] the round bit clears itself after rounding
module bcc_core #(
	parameter int REF_PER = bcc_pkg::REF_HZ
) (
	// clock and reset
	input logic core_clk,
	input logic sys_rst,
	// register port
	input logic [7:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [31:0] reg_rdata,
	// oscillator pins
	input logic osc_in_pin,
	output logic osc_out_pin,
	// power control
	output logic leakage_isolation_enable
);
	localparam int RW = $clog2(REF_PER);
	localparam int DW = $clog2(bcc_pkg::UPD_CYC);
	localparam int UPD_LAST = bcc_pkg::UPD_CYC - 1;

	function automatic logic [7:0] binc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			binc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			binc = v + 8'h01;
		end
	endfunction : binc

	// last bcd day of month; year xx00 counts as leap
	function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
		logic leap;
		leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
		case (m)
			5'h02: last_day = leap ? 6'h29 : 6'h28; // see [R9]
			5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
			default: last_day = 6'h31;
		endcase
	endfunction : last_day

	// one second step of the whole calendar
	function automatic bcc_pkg::bcc_time_t adv(input bcc_pkg::bcc_time_t t, input logic h12);
		logic dayw;
		adv = t;
		dayw = 1'b0;
		adv.sc = (t.sc == 7'h59) ? 7'h00 : 7'(binc({1'b0, t.sc})); // see [R3]
		if (t.sc == 7'h59) begin
			adv.mn = (t.mn == 7'h59) ? 7'h00 : 7'(binc({1'b0, t.mn})); // see [R3]
			if (t.mn == 7'h59) begin
				if (h12) begin
					if (t.hr == 6'h11) begin
						adv.hr = 6'h12;
						adv.pm = ~t.pm; // see [R25]
						dayw = t.pm;
					end else if (t.hr == 6'h12) begin
						adv.hr = 6'h01; // see [R25]
					end else begin
						adv.hr = 6'(binc({2'b00, t.hr})); // see [R12]
					end
				end else begin
					// meridiem left untouched in this form, see [R11]
					dayw = (t.hr == 6'h23);
					adv.hr = dayw ? 6'h00 : 6'(binc({2'b00, t.hr})); // see [R4]
				end
			end
		end
		if (dayw) begin
			adv.wd = (t.wd == 3'h6) ? 3'h0 : t.wd + 3'h1; // see [R8]
			if (t.day == last_day(t.mon, t.yr)) begin
				adv.day = 6'h01; // see [R5]
				adv.mon = (t.mon == 5'h12) ? 5'h01 : 5'(binc({3'b000, t.mon})); // see [R6]
				if (t.mon == 5'h12) begin
					adv.yr = (t.yr == 8'h99) ? 8'h00 : binc(t.yr); // see [R7]
				end
			end else begin
				adv.day = 6'(binc({2'b00, t.day})); // see [R5]
			end
		end
	endfunction : adv

	// field select by offset, shared by time and alarm sets
	function automatic logic [31:0] fld(input bcc_pkg::bcc_time_t t, input logic [7:0] a);
		fld = '0;
		case (a & bcc_pkg::FLD_MASK)
			bcc_pkg::OFS_SEC: fld[6:0] = t.sc;
			bcc_pkg::OFS_MIN: fld[6:0] = t.mn;
			bcc_pkg::OFS_HOUR: begin
				fld[5:0] = t.hr;
				fld[bcc_pkg::HB_PM] = t.pm;
			end
			bcc_pkg::OFS_DAY: fld[5:0] = t.day;
			bcc_pkg::OFS_MON: fld[4:0] = t.mon;
			bcc_pkg::OFS_YEAR: fld[7:0] = t.yr;
			bcc_pkg::OFS_WDAY: fld[2:0] = t.wd;
			default: fld = '0;
		endcase
	endfunction : fld

	// field store, bits beyond each field width are dropped
	function automatic bcc_pkg::bcc_time_t put(input bcc_pkg::bcc_time_t t,
		input logic [7:0] a, input logic [31:0] d);
		put = t;
		case (a & bcc_pkg::FLD_MASK)
			bcc_pkg::OFS_SEC: put.sc = d[6:0]; // see [R2]
			bcc_pkg::OFS_MIN: put.mn = d[6:0];
			bcc_pkg::OFS_HOUR: begin
				put.hr = d[5:0];
				put.pm = d[bcc_pkg::HB_PM];
			end
			bcc_pkg::OFS_DAY: put.day = d[5:0];
			bcc_pkg::OFS_MON: put.mon = d[4:0];
			bcc_pkg::OFS_YEAR: put.yr = d[7:0];
			bcc_pkg::OFS_WDAY: put.wd = d[2:0];
			default: put = t;
		endcase
	endfunction : put

	function automatic logic is_tc(input logic [7:0] a);
		logic [7:0] f;
		logic [7:0] g;
		f = a & bcc_pkg::FLD_MASK;
		g = a & ~bcc_pkg::FLD_MASK;
		is_tc = (g == 8'h00 || g == bcc_pkg::ALM_BASE) && f <= bcc_pkg::OFS_WDAY
			&& f[1:0] == 2'b00;
	endfunction : is_tc

	logic osc_q_reg;
	logic [RW-1:0] ref_cnt_reg;
	logic busy_reg;
	logic [DW-1:0] dly_reg;
	logic [bcc_pkg::CTRL_W-1:0] ctrl_reg;
	bcc_pkg::bcc_key_t key_reg;
	bcc_pkg::bcc_time_t cur_reg;
	bcc_pkg::bcc_time_t shd_reg;
	bcc_pkg::bcc_time_t alm_reg;
	bcc_pkg::bcc_wr_t [bcc_pkg::WR_LAT-2:0] wp_reg;
	bcc_pkg::bcc_wr_t wl;
	bcc_pkg::bcc_time_t snap;
	bcc_pkg::bcc_time_t rnd;
	logic ref_edge;
	logic counting;
	logic fire;
	logic h12;
	logic acc;
	logic rnd_now;
	logic rd_sec;

	assign h12 = ctrl_reg[bcc_pkg::CB_HFMT];
	assign counting = ctrl_reg[bcc_pkg::CB_RUN] && !ctrl_reg[bcc_pkg::CB_DIS];
	assign ref_edge = osc_in_pin && !osc_q_reg;
	// a stop during the busy window drops that second's update
	assign fire = busy_reg && dly_reg == '0 && ctrl_reg[bcc_pkg::CB_RUN]; // see [R15]
	// key registers stay writable while the rest is locked
	assign acc = reg_wr && (key_reg == bcc_pkg::KEY_OPEN
		|| reg_addr == bcc_pkg::OFS_KEY0 || reg_addr == bcc_pkg::OFS_KEY1); // see [R22]
	assign wl = wp_reg[bcc_pkg::WR_LAT-2];
	assign rd_sec = reg_rd && reg_addr == bcc_pkg::OFS_SEC;
	assign rnd_now = rd_sec && ctrl_reg[bcc_pkg::CB_RND];

	// rounding reuses the second step from :59 so carries ripple upward
	always_comb begin
		rnd = cur_reg;
		rnd.sc = 7'h59;
		if (cur_reg.sc >= 7'h30) begin
			rnd = adv(rnd, h12); // see [R14]
		end else begin
			rnd = cur_reg;
			rnd.sc = 7'h00;
		end
		snap = rnd_now ? rnd : cur_reg;
	end

	// oscillator buffer and reference divider
	always_ff @(posedge core_clk) begin
		osc_q_reg <= osc_in_pin;
		osc_out_pin <= !osc_in_pin && !ctrl_reg[bcc_pkg::CB_DIS];
		if (sys_rst) begin
			ref_cnt_reg <= '0;
		end else if (ref_edge && counting) begin
			ref_cnt_reg <= (ref_cnt_reg == RW'(REF_PER - 1)) ? '0 : ref_cnt_reg + 1'b1; // see [R1]
		end
	end

	// busy opens a fixed window ahead of every update
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
			dly_reg <= '0;
		end else if (busy_reg && dly_reg == '0) begin
			busy_reg <= 1'b0; // see [R24]
		end else if (ref_edge && counting && ref_cnt_reg == RW'(REF_PER - 1)) begin
			busy_reg <= 1'b1; // see [R24]
			dly_reg <= DW'(UPD_LAST); // see [R16]
		end else if (busy_reg) begin
			dly_reg <= dly_reg - 1'b1;
		end
	end

	// write delay line for time and alarm fields
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wp_reg <= '0;
		end else begin
			wp_reg <= {wp_reg[bcc_pkg::WR_LAT-3:0],
				{acc && is_tc(reg_addr), reg_addr, reg_wdata}}; // see [R18]
		end
	end

	// time, shadow and alarm carry no reset so a system reset keeps the time
	always_ff @(posedge core_clk) begin
		if (wl.vld && wl.addr < bcc_pkg::ALM_BASE) begin
			cur_reg <= put(cur_reg, wl.addr, wl.data); // see [R18]
		end else if (rnd_now) begin
			cur_reg <= rnd; // see [R14]
		end else if (fire) begin
			cur_reg <= adv(cur_reg, h12); // see [R1]
		end
		if (rd_sec) begin
			shd_reg <= snap; // see [R13]
		end
		if (wl.vld && wl.addr >= bcc_pkg::ALM_BASE) begin
			alm_reg <= put(alm_reg, wl.addr, wl.data); // see [R10]
		end
	end

	// control register; the round bit drops once used
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg <= bcc_pkg::CTRL_RST;
			leakage_isolation_enable <= 1'b0;
		end else begin
			if (acc && reg_addr == bcc_pkg::OFS_CTRL) begin
				ctrl_reg <= reg_wdata[bcc_pkg::CTRL_W-1:0];
			end else if (rnd_now) begin
				ctrl_reg[bcc_pkg::CB_RND] <= 1'b0; // see [R26]
			end
			leakage_isolation_enable <= ctrl_reg[bcc_pkg::CB_LEAK]; // see [R20]
		end
	end

	// unlock sequence
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			key_reg <= bcc_pkg::KEY_LOCKED;
		end else if (reg_wr && reg_addr == bcc_pkg::OFS_KEY0) begin
			key_reg <= (reg_wdata == bcc_pkg::KEY_FIRST) ? bcc_pkg::KEY_HALF
				: bcc_pkg::KEY_LOCKED; // see [R23]
		end else if (reg_wr && reg_addr == bcc_pkg::OFS_KEY1) begin
			key_reg <= (key_reg == bcc_pkg::KEY_HALF && reg_wdata == bcc_pkg::KEY_SECOND)
				? bcc_pkg::KEY_OPEN : bcc_pkg::KEY_LOCKED; // see [R23]
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst || !reg_rd) begin
			reg_rdata <= '0;
		end else if (rd_sec) begin
			reg_rdata <= fld(snap, reg_addr); // see [R13]
		end else if (is_tc(reg_addr)) begin
			reg_rdata <= fld(reg_addr >= bcc_pkg::ALM_BASE ? alm_reg : shd_reg, reg_addr);
		end else if (reg_addr == bcc_pkg::OFS_CTRL) begin
			reg_rdata <= {{(32 - bcc_pkg::CTRL_W){1'b0}}, ctrl_reg};
		end else if (reg_addr == bcc_pkg::OFS_STAT) begin
			reg_rdata <= '0;
			reg_rdata[bcc_pkg::SB_BUSY] <= busy_reg; // see [R16]
			reg_rdata[bcc_pkg::SB_RUN] <= counting;
			reg_rdata[bcc_pkg::SB_OPEN] <= key_reg == bcc_pkg::KEY_OPEN;
		end else begin
			reg_rdata <= '0;
		end
	end

	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	logic tick_clean;
	assign tick_clean = fire && !wl.vld && !rnd_now;

	sequence s_key_first;
		reg_wr && reg_addr == bcc_pkg::OFS_KEY0 && reg_wdata == bcc_pkg::KEY_FIRST;
	endsequence
	sequence s_key_second;
		reg_wr && reg_addr == bcc_pkg::OFS_KEY1 && reg_wdata == bcc_pkg::KEY_SECOND;
	endsequence
	sequence s_busy_end;
		(busy_reg && dly_reg == '0) ##1 !busy_reg;
	endsequence

	property p_unlock;
		s_key_first ##1 s_key_second |=> key_reg == bcc_pkg::KEY_OPEN;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock failed"); // see [R23]

	property p_relock;
		reg_wr && reg_addr == bcc_pkg::OFS_KEY1 && key_reg == bcc_pkg::KEY_OPEN
			|=> key_reg == bcc_pkg::KEY_LOCKED;
	endproperty
	a_relock: assert property (p_relock) else $error("relock missed"); // see [R23]

	property p_busy_win;
		$rose(busy_reg) |-> ##299 s_busy_end;
	endproperty
	a_busy_win: assert property (p_busy_win) else $error("busy window wrong"); // see [R24]

	property p_busy_lead;
		fire |-> $past(busy_reg, 299) && busy_reg;
	endproperty
	a_busy_lead: assert property (p_busy_lead) else $error("update without lead"); // see [R16]

	property p_sec_wrap;
		tick_clean && cur_reg.sc == 7'h59
			|=> cur_reg.sc == 7'h00 && cur_reg.mn != $past(cur_reg.mn);
	endproperty
	a_sec_wrap: assert property (p_sec_wrap) else $error("second carry wrong"); // see [R3]

	property p_day24;
		tick_clean && !h12 && cur_reg.hr == 6'h23 && cur_reg.mn == 7'h59
			&& cur_reg.sc == 7'h59 |=> cur_reg.hr == 6'h00 && cur_reg.wd != $past(cur_reg.wd);
	endproperty
	a_day24: assert property (p_day24) else $error("day rollover wrong"); // see [R4]

	property p_noon12;
		tick_clean && h12 && cur_reg.hr == 6'h11 && cur_reg.mn == 7'h59
			&& cur_reg.sc == 7'h59 |=> cur_reg.hr == 6'h12 && cur_reg.pm != $past(cur_reg.pm);
	endproperty
	a_noon12: assert property (p_noon12) else $error("meridiem toggle wrong"); // see [R25]

	property p_wr_lat;
		acc && reg_addr == bcc_pkg::OFS_MIN |-> ##4 cur_reg.mn == $past(reg_wdata[6:0], 4);
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write latency wrong"); // see [R18]

	property p_lock;
		reg_wr && reg_addr == bcc_pkg::OFS_CTRL && key_reg != bcc_pkg::KEY_OPEN
			|=> ctrl_reg[bcc_pkg::CB_HFMT] == $past(ctrl_reg[bcc_pkg::CB_HFMT]);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write took effect"); // see [R22]

	property p_round;
		rnd_now && !wl.vld |=> cur_reg.sc == 7'h00 && !ctrl_reg[bcc_pkg::CB_RND];
	endproperty
	a_round: assert property (p_round) else $error("rounding wrong"); // see [R14]

	property p_snap;
		rd_sec && !ctrl_reg[bcc_pkg::CB_RND] |=> shd_reg == $past(cur_reg);
	endproperty
	a_snap: assert property (p_snap) else $error("snapshot wrong"); // see [R13]

	property p_stop;
		!ctrl_reg[bcc_pkg::CB_RUN] |=> !$rose(busy_reg);
	endproperty
	a_stop: assert property (p_stop) else $error("update while stopped"); // see [R15]
endmodule : bcc_core

// ==== hdl/bcc_pkg.sv ====
// constants, field layouts and carriers of the bcd calendar clock core
// assumes a 20 MHz core clock and a plain strobe register port
package bcc_pkg;
	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_SEC = 8'h00;
	localparam logic [7:0] OFS_MIN = 8'h04;
	localparam logic [7:0] OFS_HOUR = 8'h08;
	localparam logic [7:0] OFS_DAY = 8'h0C;
	localparam logic [7:0] OFS_MON = 8'h10;
	localparam logic [7:0] OFS_YEAR = 8'h14;
	localparam logic [7:0] OFS_WDAY = 8'h18;
	localparam logic [7:0] ALM_BASE = 8'h20;
	localparam logic [7:0] FLD_MASK = 8'h1F;
	localparam logic [7:0] OFS_CTRL = 8'h40;
	localparam logic [7:0] OFS_STAT = 8'h44;
	localparam logic [7:0] OFS_KEY0 = 8'h6C;
	localparam logic [7:0] OFS_KEY1 = 8'h70;
	// control bit positions
	localparam int CB_RUN = 0;
	localparam int CB_RND = 1;
	localparam int CB_HFMT = 2;
	localparam int CB_LEAK = 3;
	localparam int CB_DIS = 4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	// status bit positions
	localparam int SB_BUSY = 0;
	localparam int SB_RUN = 1;
	localparam int SB_OPEN = 2;
	// hour register meridiem bit
	localparam int HB_PM = 7;
	// unlock keys
	localparam logic [31:0] KEY_FIRST = 32'h83E70B13;
	localparam logic [31:0] KEY_SECOND = 32'h95A4F1E0;
	// timing
	localparam int CLK_MHZ = 20;
	localparam int BUSY_US = 15;
	localparam int UPD_CYC = BUSY_US * CLK_MHZ;
	localparam int WR_LAT = 4;
	localparam int REF_HZ = 32768;
	typedef struct packed {
		logic [2:0] wd;
		logic [7:0] yr;
		logic [4:0] mon;
		logic [5:0] day;
		logic pm;
		logic [5:0] hr;
		logic [6:0] mn;
		logic [6:0] sc;
	} bcc_time_t;
	typedef struct packed {
		logic vld;
		logic [7:0] addr;
		logic [31:0] data;
	} bcc_wr_t;
	typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN} bcc_key_t;
endpackage : bcc_pkg
